// File: src/oad_cost_if.sv
// interface carrying the decoded mode and its costs
`timescale 1ns/1ps
interface oad_cost_if;
    oad_pkg::oad_mode_t mode;
    logic [2:0] reg_sel;
    logic [1:0] ext_bytes;
    logic [3:0] mode_cycles;
    logic [1:0] mode_reg_acc;
    logic [3:0] size_cycles;
    logic [2:0] data_acc;
    logic is_memory;
    modport dec (output mode, reg_sel, ext_bytes, mode_cycles, mode_reg_acc,
        size_cycles, data_acc, is_memory);
    modport use_side (input mode, reg_sel, ext_bytes, mode_cycles, mode_reg_acc,
        size_cycles, data_acc, is_memory);
endinterface : oad_cost_if

// File: src/oad_mode_decode.sv
// combinational decode of the effective-address field and size correction
`timescale 1ns/1ps
module oad_mode_decode (
    input wire logic [4:0] code,                   // effective-address field
    input wire oad_pkg::oad_size_t size,           // operand size
    input wire oad_pkg::oad_loc_t loc,             // operand location
    input wire logic odd_addr,                     // operand address is odd
    oad_cost_if.dec cost                           // decoded costs
);
    always_comb begin
        cost.reg_sel = code[2:0];
        cost.is_memory = (code >= oad_pkg::OAD_CODE_MEM_FIRST);
        cost.ext_bytes = oad_pkg::OAD_EXT_NONE;
        cost.mode_cycles = 4'h0;
        cost.mode_reg_acc = 2'h0;
        if (!cost.is_memory) begin
            // costs come from the instruction entry
            cost.mode = oad_pkg::OAD_M_REG;
        end else if (code < oad_pkg::OAD_CODE_POSTINC) begin
            cost.mode = oad_pkg::OAD_M_IND;
            cost.reg_sel = {1'b0, code[1:0]};
            cost.mode_cycles = oad_pkg::OAD_CYC_IND;
            cost.mode_reg_acc = oad_pkg::OAD_RA_ONE;
        end else if (code < oad_pkg::OAD_CODE_SHORT) begin
            cost.mode = oad_pkg::OAD_M_POSTINC;
            cost.reg_sel = {1'b0, code[1:0]};
            cost.mode_cycles = oad_pkg::OAD_CYC_POSTINC;
            cost.mode_reg_acc = oad_pkg::OAD_RA_TWO;
        end else if (code < oad_pkg::OAD_CODE_LONG) begin
            cost.mode = oad_pkg::OAD_M_SHORT;
            cost.ext_bytes = oad_pkg::OAD_EXT_ONE;
            cost.mode_cycles = oad_pkg::OAD_CYC_SHORT;
            cost.mode_reg_acc = oad_pkg::OAD_RA_ONE;
        end else if (code < oad_pkg::OAD_CODE_INDEX) begin
            cost.mode = oad_pkg::OAD_M_LONG;
            cost.reg_sel = {1'b0, code[1:0]};
            cost.ext_bytes = oad_pkg::OAD_EXT_TWO;
            cost.mode_cycles = oad_pkg::OAD_CYC_LONG;
            cost.mode_reg_acc = oad_pkg::OAD_RA_ONE;
        end else if (code < oad_pkg::OAD_CODE_PCREL) begin
            cost.mode = oad_pkg::OAD_M_INDEX;
            cost.reg_sel = {2'h0, code[0]};
            cost.mode_cycles = oad_pkg::OAD_CYC_INDEX;
            cost.mode_reg_acc = oad_pkg::OAD_RA_TWO;
        end else if (code == oad_pkg::OAD_CODE_PCREL) begin
            cost.mode = oad_pkg::OAD_M_PCREL;
            cost.ext_bytes = oad_pkg::OAD_EXT_TWO;
            cost.mode_cycles = oad_pkg::OAD_CYC_PCREL;
        end else begin
            cost.mode = oad_pkg::OAD_M_DIRECT;
            cost.ext_bytes = oad_pkg::OAD_EXT_TWO;
            cost.mode_cycles = oad_pkg::OAD_CYC_DIRECT;
        end
    end

    // size and location correction
    always_comb begin
        cost.size_cycles = 4'h0;
        cost.data_acc = oad_pkg::OAD_ACC_ONE;
        unique case (size)
            oad_pkg::OAD_SZ_BYTE: begin
                if (loc == oad_pkg::OAD_LOC_EXT16 || loc == oad_pkg::OAD_LOC_EXT8) begin
                    cost.size_cycles = oad_pkg::OAD_CORR_EXT_BYTE;
                end
            end
            oad_pkg::OAD_SZ_WORD: begin
                unique case (loc)
                    oad_pkg::OAD_LOC_REG: begin
                    end
                    oad_pkg::OAD_LOC_INT: begin
                        if (odd_addr) begin
                            cost.size_cycles = oad_pkg::OAD_CORR_INT_WORD_ODD;
                            cost.data_acc = oad_pkg::OAD_ACC_TWO;
                        end
                    end
                    oad_pkg::OAD_LOC_EXT16: begin
                        cost.size_cycles = odd_addr ? oad_pkg::OAD_CORR_E16_WORD_ODD
                            : oad_pkg::OAD_CORR_E16_WORD_EVEN;
                        cost.data_acc = odd_addr ? oad_pkg::OAD_ACC_TWO
                            : oad_pkg::OAD_ACC_ONE;
                    end
                    oad_pkg::OAD_LOC_EXT8: begin
                        cost.size_cycles = oad_pkg::OAD_CORR_E8_WORD;
                        cost.data_acc = oad_pkg::OAD_ACC_TWO;
                    end
                endcase
            end
            default: begin
                // long; size code 3 is treated as long
                cost.data_acc = oad_pkg::OAD_ACC_TWO;
                unique case (loc)
                    oad_pkg::OAD_LOC_REG: begin
                    end
                    oad_pkg::OAD_LOC_INT: begin
                        if (odd_addr) begin
                            cost.size_cycles = oad_pkg::OAD_CORR_INT_LONG_ODD;
                            cost.data_acc = oad_pkg::OAD_ACC_FOUR;
                        end
                    end
                    oad_pkg::OAD_LOC_EXT16: begin
                        cost.size_cycles = odd_addr ? oad_pkg::OAD_CORR_E16_LONG_ODD
                            : oad_pkg::OAD_CORR_E16_LONG_EVEN;
                        cost.data_acc = odd_addr ? oad_pkg::OAD_ACC_FOUR
                            : oad_pkg::OAD_ACC_TWO;
                    end
                    oad_pkg::OAD_LOC_EXT8: begin
                        cost.size_cycles = oad_pkg::OAD_CORR_E8_LONG;
                        cost.data_acc = oad_pkg::OAD_ACC_FOUR;
                    end
                endcase
            end
        endcase
    end
endmodule : oad_mode_decode

// File: src/oad_pkg.sv
// constants and types for the operand address decode and cycle costing block
// Functional notes
// - codes 00-07 are register-direct, no extension
// - direct register chosen by operand size
// - codes 08-1F are memory addressing modes
// - 08-0B indirect word reg: 2 cycles, 1 access
// - 0C-0F post increment: 4 cycles, 2 accesses
// - 10-17 short offset: 2 cycles, 1 access
// - 18-1B long offset: 2 cycles, 1 access
// - 1C-1D base plus word reg 7: 4, 2
// - 1E pc offset 2 cycles; 1F direct 1 cycle
// - extension bytes add to opcode length
// - register-direct costs come from instruction entry
// - byte: +0 internal, +1 external, one access
// - internal word: odd adds 2, two accesses
// - 16-bit bus: word +1/+4, long +2/+8
// - 8-bit bus: word +4, long +8 always
// - internal long: 2 accesses, odd 4 accesses +4
// - external wait cycles added to count
// - fetch: +2/+3 per word, +3 per byte on 8-bit
// - fetch correction is a worst-case bound
// - vector numbers: 4-bit short, 8-bit long
// - intermittent mode stall added per access
package oad_pkg;

    typedef enum logic [1:0] {
        OAD_SZ_BYTE = 2'h0,
        OAD_SZ_WORD = 2'h1,
        OAD_SZ_LONG = 2'h2
    } oad_size_t;

    typedef enum logic [1:0] {
        OAD_LOC_REG = 2'h0,
        OAD_LOC_INT = 2'h1,
        OAD_LOC_EXT16 = 2'h2,
        OAD_LOC_EXT8 = 2'h3
    } oad_loc_t;

    typedef enum logic [2:0] {
        OAD_M_REG = 3'h0,
        OAD_M_IND = 3'h1,
        OAD_M_POSTINC = 3'h2,
        OAD_M_SHORT = 3'h3,
        OAD_M_LONG = 3'h4,
        OAD_M_INDEX = 3'h5,
        OAD_M_PCREL = 3'h6,
        OAD_M_DIRECT = 3'h7
    } oad_mode_t;

    // state of the costing sequence, gray along the path
    typedef enum logic [1:0] {
        OAD_ST_IDLE = 2'h0,
        OAD_ST_SUM = 2'h1,
        OAD_ST_DONE = 2'h3
    } oad_state_t;

    localparam logic [4:0] OAD_CODE_MEM_FIRST = 5'h08;
    localparam logic [4:0] OAD_CODE_POSTINC = 5'h0C;
    localparam logic [4:0] OAD_CODE_SHORT = 5'h10;
    localparam logic [4:0] OAD_CODE_LONG = 5'h18;
    localparam logic [4:0] OAD_CODE_INDEX = 5'h1C;
    localparam logic [4:0] OAD_CODE_PCREL = 5'h1E;
    localparam logic [4:0] OAD_CODE_DIRECT = 5'h1F;
    localparam logic [2:0] OAD_INDEX_REG = 3'h7;

    localparam logic [3:0] OAD_CYC_IND = 4'h2;
    localparam logic [3:0] OAD_CYC_POSTINC = 4'h4;
    localparam logic [3:0] OAD_CYC_SHORT = 4'h2;
    localparam logic [3:0] OAD_CYC_LONG = 4'h2;
    localparam logic [3:0] OAD_CYC_INDEX = 4'h4;
    localparam logic [3:0] OAD_CYC_PCREL = 4'h2;
    localparam logic [3:0] OAD_CYC_DIRECT = 4'h1;
    localparam logic [1:0] OAD_RA_ONE = 2'h1;
    localparam logic [1:0] OAD_RA_TWO = 2'h2;

    localparam logic [1:0] OAD_EXT_NONE = 2'h0;
    localparam logic [1:0] OAD_EXT_ONE = 2'h1;
    localparam logic [1:0] OAD_EXT_TWO = 2'h2;

    localparam logic [3:0] OAD_CORR_EXT_BYTE = 4'h1;
    localparam logic [3:0] OAD_CORR_INT_WORD_ODD = 4'h2;
    localparam logic [3:0] OAD_CORR_INT_LONG_ODD = 4'h4;
    localparam logic [3:0] OAD_CORR_E16_WORD_EVEN = 4'h1;
    localparam logic [3:0] OAD_CORR_E16_WORD_ODD = 4'h4;
    localparam logic [3:0] OAD_CORR_E16_LONG_EVEN = 4'h2;
    localparam logic [3:0] OAD_CORR_E16_LONG_ODD = 4'h8;
    localparam logic [3:0] OAD_CORR_E8_WORD = 4'h4;
    localparam logic [3:0] OAD_CORR_E8_LONG = 4'h8;

    localparam logic [2:0] OAD_ACC_ONE = 3'h1;
    localparam logic [2:0] OAD_ACC_TWO = 3'h2;
    localparam logic [2:0] OAD_ACC_FOUR = 3'h4;

    localparam logic [3:0] OAD_FETCH_INT_WORD = 4'h2;
    localparam logic [3:0] OAD_FETCH_E16_WORD = 4'h3;
    localparam logic [3:0] OAD_FETCH_E8_BYTE = 4'h3;

    localparam int OAD_CNT_W = 12;
    localparam logic [OAD_CNT_W-1:0] OAD_CNT_RESET = 12'h000;

endpackage : oad_pkg

// File: src/oad_top.sv
// operand address decode and execution cycle costing
`timescale 1ns/1ps
module oad_top (
    input wire logic clk,                          // 20 MHz cpu clock
    input wire logic rst,                          // async reset, active high
    input wire logic start,                        // one-cycle request
    input wire logic [4:0] ea_code,                // effective-address field
    input wire logic [1:0] op_size,                // 0 byte, 1 word, 2 long
    input wire logic [1:0] op_loc,                 // 0 reg,1 int,2 ext16,3 ext8
    input wire logic odd_addr,                     // operand at odd address
    input wire logic [2:0] opcode_bytes,           // fixed opcode length
    input wire logic [7:0] base_cycles,            // instruction base cycles
    input wire logic [3:0] entry_mode_cycles,      // entry cycles for direct codes
    input wire logic [1:0] entry_reg_acc,          // entry reg accesses, direct codes
    input wire logic [1:0] fetch_loc,              // program memory: 1 int,2 e16,3 e8
    input wire logic [3:0] fetch_units,            // word or byte boundaries crossed
    input wire logic [7:0] wait_cycles,            // external ready waits
    input wire logic intermittent,                 // intermittent cpu mode
    input wire logic [1:0] intermittent_stall_select, // stall per access
    input wire logic [7:0] vector_field,           // vector operand field
    input wire logic vector_long,                  // 1: long vector form
    output logic busy,                             // costing in progress
    output logic done,                             // one-cycle result strobe
    output logic is_memory,                        // memory addressing mode
    output logic [2:0] mode,                       // decoded mode
    output logic [2:0] reg_sel,                    // base register number
    output logic [1:0] reg_size,                   // register width for direct
    output logic [1:0] ext_bytes,                  // address extension bytes
    output logic [3:0] instr_length,               // opcode plus extension
    output logic [3:0] mode_cycles,                // addressing cycles
    output logic [2:0] reg_accesses,               // register accesses
    output logic [3:0] size_cycles,                // size/location correction
    output logic [2:0] data_accesses,              // data accesses
    output logic [5:0] fetch_cycles,               // worst-case fetch correction
    output logic [6:0] stall_cycles,               // intermittent stall total
    output logic [oad_pkg::OAD_CNT_W-1:0] total_cycles, // total execution cycles
    output logic [7:0] short_vector_number,        // 4-bit vector
    output logic [7:0] long_vector_number          // 8-bit vector
);
    oad_cost_if cost ();

    oad_mode_decode u_dec (
        .code(ea_code),
        .size(oad_pkg::oad_size_t'(op_size)),
        .loc(oad_pkg::oad_loc_t'(op_loc)),
        .odd_addr(odd_addr),
        .cost(cost.dec)
    );

    // =====================================================
    // sequence
    oad_pkg::oad_state_t state;
    oad_pkg::oad_state_t next_state;
    logic [7:0] waits_q;
    logic [7:0] next_waits_q;
    logic [7:0] base_q;
    logic [7:0] next_base_q;
    logic [1:0] stall_sel_q;
    logic [1:0] next_stall_sel_q;
    logic stall_en_q;
    logic next_stall_en_q;

    always_comb begin
        next_state = state;
        next_waits_q = waits_q;
        next_base_q = base_q;
        next_stall_sel_q = stall_sel_q;
        next_stall_en_q = stall_en_q;
        unique case (state)
            oad_pkg::OAD_ST_IDLE: begin
                if (start) begin
                    next_state = oad_pkg::OAD_ST_SUM;
                    next_base_q = base_cycles;
                    next_stall_sel_q = intermittent_stall_select;
                    next_stall_en_q = intermittent;
                    // waits only exist with an external operand or fetch
                    next_waits_q = (op_loc[1] || fetch_loc[1]) ? wait_cycles : 8'h00;
                end
            end
            oad_pkg::OAD_ST_SUM: next_state = oad_pkg::OAD_ST_DONE;
            default: next_state = oad_pkg::OAD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= oad_pkg::OAD_ST_IDLE;
            waits_q <= 8'h00;
            base_q <= 8'h00;
            stall_sel_q <= 2'h0;
            stall_en_q <= 1'b0;
        end else begin
            state <= next_state;
            waits_q <= next_waits_q;
            base_q <= next_base_q;
            stall_sel_q <= next_stall_sel_q;
            stall_en_q <= next_stall_en_q;
        end
    end

    // =====================================================
    // result computation, captured on start; stall and total captured one cycle later in OAD_ST_SUM
    logic [2:0] c_mode;
    logic [2:0] c_reg_sel;
    logic [1:0] c_reg_size;
    logic [3:0] c_len;
    logic [3:0] c_mcyc;
    logic [2:0] c_racc;
    logic [5:0] c_fetch;
    logic [7:0] c_short_vec;
    logic [7:0] c_long_vec;

    always_comb begin
        c_mode = 3'(cost.mode);
        c_reg_sel = cost.reg_sel;
        c_reg_size = cost.is_memory ? 2'h0 : op_size;
        c_len = 4'(opcode_bytes) + 4'(cost.ext_bytes);
        if (cost.is_memory) begin
            c_mcyc = cost.mode_cycles;
            c_racc = 3'(cost.mode_reg_acc);
        end else begin
            c_mcyc = entry_mode_cycles;
            c_racc = 3'(entry_reg_acc);
        end
        // worst-case bound: every boundary assumed to delay execution
        unique case (fetch_loc)
            2'h1: c_fetch = 6'(fetch_units) * 6'(oad_pkg::OAD_FETCH_INT_WORD);
            2'h2: c_fetch = 6'(fetch_units) * 6'(oad_pkg::OAD_FETCH_E16_WORD);
            2'h3: c_fetch = 6'(fetch_units) * 6'(oad_pkg::OAD_FETCH_E8_BYTE);
            default: c_fetch = 6'h00;
        endcase
        c_short_vec = {4'h0, vector_field[3:0]};
        c_long_vec = vector_long ? vector_field : 8'h00;
    end

    logic [6:0] c_stall;
    logic [oad_pkg::OAD_CNT_W-1:0] c_total;
    always_comb begin
        // every register and data access stalls in intermittent mode
        c_stall = stall_en_q ? 7'(({1'b0, reg_accesses} + {1'b0, data_accesses})
            * ({2'h0, stall_sel_q} + 4'h1)) : 7'h00;
        c_total = 12'(base_q) + 12'(mode_cycles) + 12'(size_cycles)
            + 12'(fetch_cycles) + 12'(waits_q) + 12'(c_stall);
    end

    logic sample;
    assign sample = (state == oad_pkg::OAD_ST_IDLE) && start;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= 3'h0;
            reg_sel <= 3'h0;
            reg_size <= 2'h0;
            ext_bytes <= 2'h0;
            instr_length <= 4'h0;
            mode_cycles <= 4'h0;
            reg_accesses <= 3'h0;
            size_cycles <= 4'h0;
            data_accesses <= 3'h0;
            fetch_cycles <= 6'h00;
            is_memory <= 1'b0;
            short_vector_number <= 8'h00;
            long_vector_number <= 8'h00;
            stall_cycles <= 7'h00;
            total_cycles <= oad_pkg::OAD_CNT_RESET;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= (next_state != oad_pkg::OAD_ST_IDLE);
            done <= (state == oad_pkg::OAD_ST_SUM);
            if (sample) begin
                mode <= c_mode;
                reg_sel <= c_reg_sel;
                reg_size <= c_reg_size;
                ext_bytes <= cost.ext_bytes;
                instr_length <= c_len;
                mode_cycles <= c_mcyc;
                reg_accesses <= c_racc;
                size_cycles <= cost.size_cycles;
                data_accesses <= cost.data_acc;
                fetch_cycles <= c_fetch;
                is_memory <= cost.is_memory;
                short_vector_number <= c_short_vec;
                long_vector_number <= c_long_vec;
            end
            if (state == oad_pkg::OAD_ST_SUM) begin
                stall_cycles <= c_stall;
                total_cycles <= c_total;
            end
        end
    end
endmodule : oad_top

// File: verification/oad_bus_model.sv
// far-side bus model: ready wait cycles for one operand access
`timescale 1ns/1ps
module oad_bus_model (
    input wire logic clk,           // cpu clock
    input wire logic rst,           // async reset, active high
    input wire logic slow,          // 1: bus stretches accesses
    input wire logic take,          // request accepted by the block
    output logic [7:0] wait_cycles  // waits seen by this access
);
    logic [7:0] pending;
    // new wait figure after each accepted request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 8'h00;
        end else if (take) begin
            pending <= 8'($urandom_range(1, 15));
        end
    end
    assign wait_cycles = slow ? pending : 8'h00;
endmodule : oad_bus_model

// File: verification/oad_checker.sv
// concurrent checks on the ports of the costing block
`timescale 1ns/1ps
module oad_checker (
    input wire logic clk,                  // cpu clock
    input wire logic rst,                  // async reset
    input wire logic start,                // request
    input wire logic [4:0] ea_code,        // address field
    input wire logic [1:0] op_size,        // operand size
    input wire logic [2:0] opcode_bytes,   // opcode length
    input wire logic [1:0] fetch_loc,      // program memory
    input wire logic [3:0] fetch_units,    // fetch units
    input wire logic intermittent,         // intermittent mode
    input wire logic [7:0] vector_field,   // vector field
    input wire logic busy,                 // busy
    input wire logic done,                 // result strobe
    input wire logic is_memory,            // memory mode
    input wire logic [2:0] mode,           // decoded mode
    input wire logic [2:0] reg_sel,        // base register
    input wire logic [1:0] reg_size,       // register width
    input wire logic [1:0] ext_bytes,      // extension bytes
    input wire logic [3:0] instr_length,   // length
    input wire logic [3:0] mode_cycles,    // mode cycles
    input wire logic [2:0] reg_accesses,   // register accesses
    input wire logic [5:0] fetch_cycles,   // fetch correction
    input wire logic [6:0] stall_cycles,   // stall total
    input wire logic [7:0] short_vector_number // short vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take = start && !busy;

    function automatic logic [1:0] ext_of(input logic [4:0] c);
        if (c >= 5'h10 && c <= 5'h17) return 2'h1;
        if ((c >= 5'h18 && c <= 5'h1B) || c >= 5'h1E) return 2'h2;
        return 2'h0;
    endfunction : ext_of

    property p_answer; take |=> busy ##1 (done && busy); endproperty
    a_answer: assert property (p_answer) else $error("result strobe late");
    property p_done_pulse; done |=> !done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("strobe too long");
    property p_direct;
        take && ea_code < 5'h08 |=> !is_memory && mode == 3'h0 && ext_bytes == 2'h0
            && reg_sel == 3'($past(ea_code)) && reg_size == $past(op_size);
    endproperty
    a_direct: assert property (p_direct) else $error("direct decode wrong");
    property p_mem;
        take && ea_code >= 5'h08 |=> is_memory && ext_bytes == ext_of($past(ea_code));
    endproperty
    a_mem: assert property (p_mem) else $error("memory decode wrong");
    property p_postinc;
        take && ea_code[4:2] == 3'h3 |=> mode_cycles == 4'h4 && reg_accesses == 3'h2;
    endproperty
    a_postinc: assert property (p_postinc) else $error("post increment cost wrong");
    property p_noreg;
        take && ea_code >= 5'h1E |=> reg_accesses == 3'h0
            && mode_cycles == ($past(ea_code) == 5'h1F ? 4'h1 : 4'h2);
    endproperty
    a_noreg: assert property (p_noreg) else $error("pc or direct cost wrong");
    property p_length;
        done |-> instr_length == 4'($past(opcode_bytes, 2)) + 4'(ext_bytes);
    endproperty
    a_length: assert property (p_length) else $error("length wrong");
    property p_fetch;
        done |-> fetch_cycles == ($past(fetch_loc, 2) == 2'h0 ? 6'h00
            : 6'($past(fetch_units, 2)) * ($past(fetch_loc, 2) == 2'h1 ? 6'h02 : 6'h03));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch correction wrong");
    property p_vector;
        done |-> short_vector_number == (8'h0F & $past(vector_field, 2));
    endproperty
    a_vector: assert property (p_vector) else $error("short vector wrong");
    property p_stall; done && !$past(intermittent, 2) |-> stall_cycles == 7'h00; endproperty
    a_stall: assert property (p_stall) else $error("stall outside mode");
    c_direct: cover property (take && ea_code < 5'h08);
    c_abs: cover property (take && ea_code == 5'h1F);
    c_stall: cover property (done && stall_cycles != 7'h00);
endmodule : oad_checker

bind oad_top oad_checker i_checker (.*);

// File: verification/oad_top_tb.sv
// self-checking bench for the costing block
`timescale 1ns/1ps
module oad_top_tb;
    logic clk = 0, rst = 1, start = 0, odd_addr = 0, intermittent = 0, vector_long = 0;
    logic slow = 0, busy, done, is_memory;
    logic [4:0] ea_code = 0;
    logic [1:0] op_size = 0, op_loc = 0, fetch_loc = 0, entry_reg_acc = 0;
    logic [1:0] intermittent_stall_select = 0, reg_size, ext_bytes;
    logic [2:0] opcode_bytes = 0, mode, reg_sel, reg_accesses, data_accesses;
    logic [3:0] entry_mode_cycles = 0, fetch_units = 0, instr_length, mode_cycles, size_cycles;
    logic [7:0] base_cycles = 0, vector_field = 0, short_vector_number, long_vector_number;
    logic [5:0] fetch_cycles;
    logic [6:0] stall_cycles;
    logic [11:0] total_cycles;
    wire logic [7:0] wait_cycles;
    int mismatches = 0, n_checks = 0;
    int mcy[8] = '{0, 2, 4, 2, 2, 4, 2, 1};
    int rac[8] = '{0, 1, 2, 1, 1, 2, 0, 0};
    int exb[8] = '{0, 0, 0, 1, 2, 0, 2, 2};
    int wsc[8] = '{0, 0, 0, 2, 1, 4, 4, 4};

    always #25 clk = ~clk;

    oad_top i_dut (.*);

    oad_bus_model i_bus (.clk(clk), .rst(rst), .slow(slow), .take(start && !busy),
        .wait_cycles(wait_cycles));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk_field(input logic [15:0] got, input int exp);
        n_checks++;
        if (got !== 16'(exp)) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_field

    task automatic chk_count(input logic [15:0] got, input int exp);
        n_checks++;
        if (got !== 16'(exp)) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_count

    task automatic run_op(input int code, input int sz, input int loc, input int odd,
            input int fl, input int im, input int poke);
        int md, mc, ra, sc, da, fc, wt, st, k;
        @(posedge clk);
        ea_code <= 5'(code);
        op_size <= 2'(sz);
        op_loc <= 2'(loc);
        odd_addr <= 1'(odd);
        fetch_loc <= 2'(fl);
        intermittent <= 1'(im);
        opcode_bytes <= 3'($urandom_range(1, 4));
        base_cycles <= 8'($urandom);
        entry_mode_cycles <= 4'($urandom);
        entry_reg_acc <= 2'($urandom);
        fetch_units <= 4'($urandom);
        intermittent_stall_select <= 2'($urandom);
        vector_field <= 8'($urandom);
        vector_long <= 1'($urandom);
        slow <= 1'($urandom);
        start <= 1'b1;
        #1;
        md = code < 8 ? 0 : code < 12 ? 1 : code < 16 ? 2 : code < 24 ? 3 : code < 28 ? 4
            : code < 30 ? 5 : code - 24;
        mc = md == 0 ? int'(entry_mode_cycles) : mcy[md];
        ra = md == 0 ? int'(entry_reg_acc) : rac[md];
        sc = sz == 0 ? int'(loc >= 2) : wsc[loc * 2 + odd] * (sz == 1 ? 1 : 2);
        da = sz == 0 ? 1 : ((loc == 3 || (odd != 0 && loc != 0)) ? 2 : 1) * (sz == 1 ? 1 : 2);
        fc = int'(fetch_units) * (fl == 0 ? 0 : fl == 1 ? 2 : 3);
        wt = (loc >= 2 || fl >= 2) ? int'(wait_cycles) : 0;
        st = im != 0 ? (ra + da) * (int'(intermittent_stall_select) + 1) : 0;
        @(posedge clk);
        start <= 1'(poke);
        ea_code <= 5'(poke != 0 ? ~code : code);
        k = 0;
        #1;
        while (done !== 1'b1 && k < 8) begin
            @(posedge clk);
            start <= 1'b0;
            #1;
            k++;
        end
        if (done !== 1'b1) begin
            mismatches++;
            results();
        end
        chk_field(mode, md);
        chk_field(is_memory, int'(md != 0));
        if (md < 6) begin
            chk_field(reg_sel, (md == 0 || md == 3) ? code % 8 : md == 5 ? code % 2 : code % 4);
        end
        chk_field(reg_size, md == 0 ? sz : 0);
        chk_field(ext_bytes, exb[md]);
        chk_count(instr_length, int'(opcode_bytes) + exb[md]);
        chk_count(mode_cycles, mc);
        chk_count(reg_accesses, ra);
        chk_count(size_cycles, sc);
        chk_count(data_accesses, da);
        chk_count(fetch_cycles, fc);
        chk_count(stall_cycles, st);
        chk_count(total_cycles, int'(base_cycles) + mc + sc + fc + wt + st);
        chk_field(short_vector_number, int'(vector_field) % 16);
        chk_field(long_vector_number, vector_long ? int'(vector_field) : 0);
        @(posedge clk);
        #1;
        chk_field({busy, done}, 0);
    endtask : run_op

    initial begin
        void'($urandom(44));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < 32; c++) begin
            run_op(c, $urandom_range(0, 3), $urandom_range(0, 3), $urandom_range(0, 1),
                $urandom_range(0, 3), 0, int'(c % 5 == 0));
        end
        for (int i = 0; i < 24; i++) begin
            run_op(8 + i % 24, i % 3, i / 6, (i / 3) % 2, i / 6, 1, 0);
        end
        repeat (60) begin
            run_op($urandom_range(0, 31), $urandom_range(0, 2), $urandom_range(0, 3),
                $urandom_range(0, 1), $urandom_range(0, 3), $urandom_range(0, 1), 0);
        end
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk_count(total_cycles, 0);
        chk_field({busy, done, is_memory}, 0);
        @(posedge clk);
        rst <= 1'b0;
        run_op(5'h1D, 3, 2, 1, 3, 1, 0);
        results();
    end
endmodule : oad_top_tb
